/* File: verilog/ivt_defs.svh */
/*
 * constants for the interrupt enable and vlan tag register slice:
 * offsets, field positions, reset values.
 * assumes inclusion by bare name; definitions only.
 */
// Overview of operation
// RULE1 - pending passes status only when enabled
// RULE2 - one enable bit per status condition
// RULE3 - enable bits 31:9 read zero
// RULE4 - bit 8 enables phy reset done
// RULE5 - bits 7,6,5: ready, clock lock, tx done
// RULE6 - bits 4,3,2: overrun, refused, rx done
// RULE7 - bits 1,0: negotiation, mac access done
// RULE8 - pending bit 1 shows negotiation done
// RULE9 - pending bit 0 shows mac access done
// RULE10 - tag registers act only when built in
// RULE11 - tx tag inserted after source address
// RULE12 - rx tag inserted after source address
// RULE13 - tag registers rw, reset zero, fields
// RULE14 - pending 5 tx done, 2 rx done
// RULE15 - pending is status and enable combined
`ifndef IVT_DEFS_SVH
`define IVT_DEFS_SVH
`define IVT_ADDR_STATUS 8'h0C
`define IVT_ADDR_PENDING 8'h10
`define IVT_ADDR_ENABLE 8'h14
`define IVT_ADDR_TXTAG 8'h18
`define IVT_ADDR_RXTAG 8'h1C
`define IVT_ADDR_MASK 8'h20
`define IVT_NUM_IRQ 9
`define IVT_BIT_PHYRST 8
`define IVT_BIT_XCVRRDY 7
`define IVT_BIT_RXLOCK 6
`define IVT_BIT_TXDONE 5
`define IVT_BIT_RXOVR 4
`define IVT_BIT_RXREF 3
`define IVT_BIT_RXDONE 2
`define IVT_BIT_NEG 1
`define IVT_BIT_MACACC 0
`define IVT_IRQ_RST 9'h000
`define IVT_TAG_RST 32'h0000_0000
`define IVT_TAG_TPID_HI 31
`define IVT_TAG_TPID_LO 16
`define IVT_TAG_PRI_HI 15
`define IVT_TAG_PRI_LO 13
`define IVT_TAG_CFI 12
`define IVT_TAG_VID_HI 11
`endif

/* File: verilog/ivt_pkg.sv */
/*
 * types for the interrupt enable and vlan tag register slice.
 * assumes ivt_defs.svh on the include path.
 */
`default_nettype none
`include "ivt_defs.svh"
package ivt_pkg;
    typedef logic [`IVT_NUM_IRQ-1:0] ivt_irq_t;

    // tag layout: tpid, priority, cfi, vlan id
    typedef struct packed {
        logic [15:0] tpid;
        logic [2:0] priority_;
        logic cfi;
        logic [11:0] vid;
    } ivt_tag_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ivt_bus_t;

    typedef struct packed {
        ivt_irq_t status;
        ivt_irq_t enable;
        ivt_irq_t pending;
        ivt_irq_t mask;
        ivt_tag_t txTag;
        ivt_tag_t rxTag;
        logic [31:0] rdata;
        logic irq;
        ivt_tag_t txTagOut;
        ivt_tag_t rxTagOut;
        logic txTagEn;
        logic rxTagEn;
    } ivt_state_t;
endpackage
`default_nettype wire

/* File: verilog/ivt_regs.sv */
/*
 * interrupt enable, pending and vlan tag register slice.
 * assumes single clock, events arrive as same-clock one-cycle pulses
 * from the mac datapath; the tag outputs feed a datapath that inserts
 * the tag word right after the source address.
 */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ivt_defs.svh"
module ivt_regs
    import ivt_pkg::*;
#(
    parameter bit BUILD_TX_TAGGING = 1'b1,
    parameter bit BUILD_RX_TAGGING = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic [`IVT_NUM_IRQ-1:0] eventIn,
    output logic irq,
    output logic [`IVT_NUM_IRQ-1:0] pendingOut,
    output logic [31:0] txTagOut,
    output logic [31:0] rxTagOut,
    output logic txTagEnable,
    output logic rxTagEnable
);
    ivt_state_t state_r;
    ivt_state_t state_nxt;
    ivt_bus_t bus;

    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    always_comb begin
        ivt_irq_t statusNew;
        ivt_irq_t w1c;
        logic [31:0] rdata;
        statusNew = '0;
        w1c = '0;
        rdata = 32'h0000_0000;
        state_nxt = state_r;
        if (bus.wr && bus.addr == `IVT_ADDR_STATUS) begin
            w1c = bus.wdata[`IVT_NUM_IRQ-1:0];
        end
        // set beats clear so an event in the clearing cycle is kept
        statusNew = (state_r.status & ~w1c) | eventIn;
        state_nxt.status = statusNew;
        if (bus.wr) begin
            case (bus.addr)
                // one enable per status condition, same position [RULE2]
                // bits 8..0: phy reset [RULE4] ready, lock, tx [RULE5]
                // overrun, refused, rx [RULE6] negotiation, access [RULE7]
                `IVT_ADDR_ENABLE: state_nxt.enable =
                    bus.wdata[`IVT_NUM_IRQ-1:0];
                `IVT_ADDR_MASK: state_nxt.mask = bus.wdata[`IVT_NUM_IRQ-1:0];
                `IVT_ADDR_TXTAG: state_nxt.txTag = bus.wdata; // [RULE13]
                `IVT_ADDR_RXTAG: state_nxt.rxTag = bus.wdata; // [RULE13]
                default: ;
            endcase
        end
        // status passes to pending only where enabled [RULE1] [RULE15]
        // bit 1 negotiation [RULE8], bit 0 access [RULE9], 5/2 [RULE14]
        state_nxt.pending = statusNew & state_nxt.enable;
        state_nxt.irq = |(state_nxt.pending & state_nxt.mask);
        if (bus.rd) begin
            case (bus.addr)
                `IVT_ADDR_STATUS: rdata = {23'h00_0000, state_r.status};
                `IVT_ADDR_PENDING: rdata = {23'h00_0000, state_r.pending};
                // upper bits are reserved and read zero [RULE3]
                `IVT_ADDR_ENABLE: rdata = {23'h00_0000, state_r.enable};
                `IVT_ADDR_TXTAG: rdata = state_r.txTag;
                `IVT_ADDR_RXTAG: rdata = state_r.rxTag;
                `IVT_ADDR_MASK: rdata = {23'h00_0000, state_r.mask};
                default: rdata = 32'h0000_0000;
            endcase
        end
        state_nxt.rdata = rdata;
        // tag registers drive the datapath only when built in [RULE10]
        // datapath puts these words after the source address [RULE11] [RULE12]
        state_nxt.txTagEn = BUILD_TX_TAGGING;
        state_nxt.rxTagEn = BUILD_RX_TAGGING;
        state_nxt.txTagOut = BUILD_TX_TAGGING ? state_nxt.txTag : '0;
        state_nxt.rxTagOut = BUILD_RX_TAGGING ? state_nxt.rxTag : '0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign regRdata = state_r.rdata;
    assign irq = state_r.irq;
    assign pendingOut = state_r.pending;
    assign txTagOut = state_r.txTagOut;
    assign rxTagOut = state_r.rxTagOut;
    assign txTagEnable = state_r.txTagEn;
    assign rxTagEnable = state_r.rxTagEn;

    sequence seqEnableWrite(int b);
        regWr && regAddr == `IVT_ADDR_ENABLE && regWdata[b];
    endsequence

    chk_pending_gated: // [RULE1]
        assert property (@(posedge clk) disable iff (!rst_n)
        (pendingOut & ~state_r.enable) == '0)
        else $error("pending bit set while enable clear");
    chk_pending_and: // [RULE15]
        assert property (@(posedge clk) disable iff (!rst_n)
        ##1 pendingOut == ((($past(state_r.status) & ~($past(regWr) &&
        $past(regAddr) == `IVT_ADDR_STATUS ? $past(regWdata[8:0]) : 9'h000))
        | $past(eventIn)) & state_r.enable))
        else $error("pending is not status and enable");
    chk_enable_write: // [RULE4]
        assert property (@(posedge clk) disable iff (!rst_n)
        seqEnableWrite(`IVT_BIT_PHYRST) |=> state_r.enable[8])
        else $error("enable bit 8 did not store");
    chk_enable_rsvd: // [RULE3]
        assert property (@(posedge clk) disable iff (!rst_n)
        regRd && regAddr == `IVT_ADDR_ENABLE |=> regRdata[31:9] == '0)
        else $error("reserved enable bits read nonzero");
    chk_enable_read: // [RULE2]
        assert property (@(posedge clk) disable iff (!rst_n)
        regRd && regAddr == `IVT_ADDR_ENABLE |=>
        regRdata[8:0] == $past(state_r.enable))
        else $error("enable readback wrong");
    chk_event_pend: // [RULE8]
        assert property (@(posedge clk) disable iff (!rst_n)
        eventIn[`IVT_BIT_NEG] && state_r.enable[1] && !regWr
        |=> pendingOut[1])
        else $error("negotiation event not pending");
    chk_access_pend: // [RULE9]
        assert property (@(posedge clk) disable iff (!rst_n)
        eventIn[0] && state_r.enable[0] && !regWr |=> pendingOut[0])
        else $error("access event not pending");
    chk_txtag_write: // [RULE11]
        assert property (@(posedge clk) disable iff (!rst_n)
        regWr && regAddr == `IVT_ADDR_TXTAG |=>
        txTagOut == (BUILD_TX_TAGGING ? $past(regWdata) : 32'h0000_0000))
        else $error("tx tag not applied");
    chk_rxtag_write: // [RULE12]
        assert property (@(posedge clk) disable iff (!rst_n)
        regWr && regAddr == `IVT_ADDR_RXTAG |=>
        rxTagOut == (BUILD_RX_TAGGING ? $past(regWdata) : 32'h0000_0000))
        else $error("rx tag not applied");
    chk_irq_level: // [RULE1]
        assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(pendingOut & state_r.mask))
        else $error("interrupt level mismatch");
endmodule // ivt_regs
`default_nettype wire

/* File: dv/test_ivt_regs.sv */
/* self-checking bench for ivt_regs: enable, pending, irq and tag regs.
   assumes the register port timing and event pulses of the design. */
`timescale 1ns/1ps
`default_nettype none
module test_ivt_regs;
    logic clk, rst_n, regWr, regRd, irq, txTagEnable, rxTagEnable;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, txTagOut, rxTagOut;
    logic [8:0] eventIn, pendingOut;
    int err_count = 0;
    int cmp_count = 0;

    ivt_regs dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .eventIn(eventIn), .irq(irq),
        .pendingOut(pendingOut), .txTagOut(txTagOut),
        .rxTagOut(rxTagOut), .txTagEnable(txTagEnable),
        .rxTagEnable(rxTagEnable));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // returns 1 ns after the taking edge, so effects are already settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(nm, e, regRdata);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic t_reset;
        rchk("enable", 8'h14, 32'h0000_0000);
        rchk("txtag", 8'h18, 32'h0000_0000);
        rchk("rxtag", 8'h1C, 32'h0000_0000);
    endtask

    task automatic t_width;
        wr(8'h14, 32'hFFFF_FFFF);
        rchk("enable", 8'h14, 32'h0000_01FF);
        wr(8'h14, 32'h0000_0000);
        rchk("enable", 8'h14, 32'h0000_0000);
    endtask

    // status is loaded while all enables are off, then opened one by one
    task automatic t_gate;
        @(posedge clk);
        eventIn <= 9'h1FF;
        @(posedge clk);
        eventIn <= 9'h000;
        #1;
        chk("pending", 32'h0000_0000, {23'h0, pendingOut});
        for (int i = 0; i < 9; i++) begin
            wr(8'h14, 32'h0000_0001 << i);
            chk("pending", 32'h0000_0001 << i, {23'h0, pendingOut});
            rchk("pendreg", 8'h10, 32'h0000_0001 << i);
        end
        wr(8'h14, 32'h0000_0000);
        chk("pending", 32'h0000_0000, {23'h0, pendingOut});
    endtask

    task automatic t_irq;
        wr(8'h14, 32'h0000_0020);
        wr(8'h20, 32'h0000_0010);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        wr(8'h20, 32'h0000_0020);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        wr(8'h0C, 32'h0000_0020);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        chk("pending", 32'h0000_0000, {23'h0, pendingOut});
    endtask

    task automatic t_tags;
        wr(8'h18, 32'h8100_A123);
        wr(8'h1C, 32'h88A8_F0FF);
        chk("txout", 32'h8100_A123, txTagOut);
        chk("rxout", 32'h88A8_F0FF, rxTagOut);
        rchk("txtag", 8'h18, 32'h8100_A123);
        rchk("rxtag", 8'h1C, 32'h88A8_F0FF);
        chk("tagen", 32'h0000_0003, {30'h0, txTagEnable, rxTagEnable});
        rchk("unmapped", 8'h40, 32'h0000_0000);
    endtask

    initial begin
        rst_n = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0000_0000;
        eventIn = 9'h000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_width;
        t_gate;
        t_irq;
        t_tags;
        final_report;
    end

    // the whole sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        final_report;
    end
endmodule // test_ivt_regs
`default_nettype wire
